// *** rtl/sfr_array.v ***
// Memory array with one write port for loading and one registered read port.
// Assumes a single clock; read data appear one enabled cycle after rdEn.
`timescale 1ns/1ps
module sfr_array #(
  parameter AW = 20,
  parameter DW = 8
) (
  // Clock
  input wire clk,
  input wire clkEn,
  // Load port
  input wire wrEn,
  input wire [AW-1:0] wrAddr,
  input wire [DW-1:0] wrData,
  // Read port
  input wire rdEn,
  input wire [AW-1:0] rdAddr,
  output reg [DW-1:0] rdData
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge clk) begin
    if (clkEn) begin
      if (wrEn) begin
        mem[wrAddr] <= wrData;
      end
      if (rdEn) begin
        rdData <= mem[rdAddr];
      end
    end
  end
endmodule

// *** rtl/sfr_fifo.v ***
// Synchronous FIFO with valid/ready on both sides and a flush.
// Assumes DEPTH is a power of two; flush wins over push and pop.
`timescale 1ns/1ps
module sfr_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32
) (
  // Clock and reset
  input wire clk,
  input wire resetn,
  input wire clkEn,
  input wire flush,
  // Fill side
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  // Drain side
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData
);
  localparam PW = $clog2(DEPTH);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [PW:0] wrPtr_q;
  reg [PW:0] rdPtr_q;
  wire push;
  wire pop;

  assign inReady = (wrPtr_q[PW-1:0] != rdPtr_q[PW-1:0]) || (wrPtr_q[PW] == rdPtr_q[PW]);
  assign outValid = (wrPtr_q != rdPtr_q);
  assign outData = mem[rdPtr_q[PW-1:0]];
  assign push = inValid & inReady;
  assign pop = outValid & outReady;

  always @(posedge clk) begin
    if (!resetn) begin
      wrPtr_q <= {(PW+1){1'b0}};
      rdPtr_q <= {(PW+1){1'b0}};
    end else if (clkEn) begin
      if (flush) begin
        wrPtr_q <= {(PW+1){1'b0}};
        rdPtr_q <= {(PW+1){1'b0}};
      end else begin
        if (push) begin
          mem[wrPtr_q[PW-1:0]] <= inData;
          wrPtr_q <= wrPtr_q + {{PW{1'b0}}, 1'b1};
        end
        if (pop) begin
          rdPtr_q <= rdPtr_q + {{PW{1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule

// *** rtl/sfr_multi_io_read.v ***
// Read front end of a serial NOR flash slave: single, dual and quad reads
// with continuous read mode. Assumes the serial pins are asynchronous to clk
// and that clk runs at least eight times faster than the serial clock.
//
// Summary of operation
// - Fast read: opcode 0BH, 24-bit address, dummy byte, all sampled on rising edge.
// - Fast read data leaves on one line per falling edge, MSB first.
// - Any start address; address advances by one per byte sent.
// - Address counter wraps from the last array location to zero.
// - Chip select high ends any read and stops driving data.
// - Fast read during a busy write cycle is ignored.
// - Dual-output read 3BH: serial command and address, data on two lines.
// - Dual-output read has eight dummy clocks whose inputs are ignored.
// - Dual-I/O read BBH: serial opcode, address two bits per clock.
// - Dual-I/O data two bits per falling edge, address per byte.
// - Dual-I/O mode bits 5:4 equal 10 skip the next opcode.
// - Other dual-I/O mode bits return to full opcode decoding.
// - Continuous-mode reset clears stored mode bits.
// - Quad opcodes accepted only while the quad enable bit is one; continuous quad reads skip the check.
// - Quad-output read 6BH: serial address, eight dummy clocks, four-bit data.
// - Quad-I/O read EBH: only opcode serial, rest four bits per clock.
// - Quad-I/O read has six clocks between address and data.
// - First two of those clocks carry the mode byte, four are dummy.
// - Quad-I/O mode bits 5:4 equal 10 make next selection address-first.
// - Other mode bits in continuous access leave continuous mode.
// - Quad-I/O read during a busy write cycle is rejected.
// - Write-in-progress bit is one for the whole busy cycle; here it follows cycleBusy one enabled clk cycle late.
`timescale 1ns/1ps
`include "sfr_read_regs.vh"
module sfr_multi_io_read #(
  parameter ARRAY_AW = `SFR_ARRAY_AW,
  parameter FIFO_DEPTH = `SFR_FIFO_DEPTH
) (
  // Clock, reset, enable
  input wire clk,
  input wire resetn,
  input wire clkEn,
  // Serial link pins
  input wire csN,
  input wire sclk,
  input wire [3:0] dataLineIn,
  output wire [3:0] dataLineOut,
  output wire [3:0] dataLineOe,
  // Status and configuration
  input wire quadEnableBit,
  input wire cycleBusy,
  input wire contModeClear,
  output wire writeInProgressBit,
  output wire continuousModeActive,
  output wire readActive,
  output wire readRejected,
  // Array load port
  input wire loadEn,
  input wire [ARRAY_AW-1:0] loadAddr,
  input wire [7:0] loadData
);
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_CMD = 3'h1;
  localparam [2:0] ST_ADDR = 3'h2;
  localparam [2:0] ST_MODE = 3'h3;
  localparam [2:0] ST_DUMMY = 3'h4;
  localparam [2:0] ST_DATA = 3'h5;
  localparam [2:0] ST_REJECT = 3'h6;

  localparam [2:0] TY_FAST = 3'h0;
  localparam [2:0] TY_DOUT = 3'h1;
  localparam [2:0] TY_DIO = 3'h2;
  localparam [2:0] TY_QOUT = 3'h3;
  localparam [2:0] TY_QIO = 3'h4;

  localparam [1:0] CONT_NONE = 2'h0;
  localparam [1:0] CONT_DUAL = 2'h1;
  localparam [1:0] CONT_QUAD = 2'h2;

  // Pin synchronisers and edge detection
  reg [5:0] syncA_q;
  reg [5:0] syncB_q;
  reg sclkPrev_q;
  wire selected = ~syncB_q[5];
  wire sclkNow = syncB_q[4];
  wire [3:0] din = syncB_q[3:0];
  wire sclkRise = sclkNow & ~sclkPrev_q;
  wire sclkFall = ~sclkNow & sclkPrev_q;

  // Command state
  reg [2:0] state_q;
  reg [2:0] type_q;
  reg [4:0] cnt_q;
  reg [23:0] sr_q;
  reg [1:0] contMode_q;
  reg wip_q;

  // Data output state
  reg [7:0] outSr_q;
  reg [2:0] outCnt_q;
  reg [3:0] dataOut_q;
  reg [3:0] dataOe_q;

  // Prefetch state
  reg [ARRAY_AW-1:0] fetchAddr_q;
  reg fetchOn_q;
  reg inflight_q;
  wire [7:0] arrayData;
  wire fifoInReady;
  wire fifoOutValid;
  wire [7:0] fifoOutData;

  // Entry decisions for a fresh selection
  reg [2:0] stCur;
  reg [2:0] tyCur;
  always @* begin
    stCur = state_q;
    tyCur = type_q;
    if (state_q == ST_IDLE) begin
      if (contMode_q == CONT_NONE) begin
        stCur = ST_CMD;
      end else if (cycleBusy) begin
        stCur = ST_REJECT;
      end else begin
        stCur = ST_ADDR;
        tyCur = (contMode_q == CONT_QUAD) ? TY_QIO : TY_DIO;
      end
    end
  end

  // Phase geometry per read type
  reg [2:0] addrLanes;
  reg [2:0] dataLanes;
  reg [4:0] addrClks;
  reg [4:0] modeClks;
  reg [4:0] dummyClks;
  always @* begin
    addrLanes = 3'h1;
    dataLanes = 3'h1;
    addrClks = `SFR_ADDR_CLKS_X1;
    modeClks = 5'h00;
    dummyClks = `SFR_DUMMY_CLKS_SER;
    case (tyCur)
      TY_FAST: begin
        dataLanes = 3'h1;
      end
      TY_DOUT: begin
        dataLanes = 3'h2;
      end
      TY_DIO: begin
        addrLanes = 3'h2;
        dataLanes = 3'h2;
        addrClks = `SFR_ADDR_CLKS_X2;
        modeClks = `SFR_MODE_CLKS_DIO;
        dummyClks = 5'h00;
      end
      TY_QOUT: begin
        dataLanes = 3'h4;
      end
      TY_QIO: begin
        addrLanes = 3'h4;
        dataLanes = 3'h4;
        addrClks = `SFR_ADDR_CLKS_X4;
        modeClks = `SFR_MODE_CLKS_QIO;
        dummyClks = `SFR_DUMMY_CLKS_QIO;
      end
      default: begin
        dataLanes = 3'h1;
      end
    endcase
  end

  // Input shifting, MSB first, highest line carries the oldest bit
  wire [2:0] inLanes = (stCur == ST_CMD) ? 3'h1 : addrLanes;
  reg [23:0] shifted;
  always @* begin
    case (inLanes)
      3'h2: shifted = {sr_q[21:0], din[1:0]};
      3'h4: shifted = {sr_q[19:0], din[3:0]};
      default: shifted = {sr_q[22:0], din[0]};
    endcase
  end
  wire [7:0] opcode = shifted[7:0];
  wire [4:0] cntNext = cnt_q + 5'h01;

  // Output byte selection for the falling edge
  wire popByte = (state_q == ST_DATA) & sclkFall & (outCnt_q == 3'h0);
  wire [7:0] byteNow = (outCnt_q == 3'h0) ? fifoOutData : outSr_q;
  wire fetchIssue = fetchOn_q & ~inflight_q & fifoInReady;

  always @(posedge clk) begin
    if (!resetn) begin
      syncA_q <= 6'h20; // Idle link levels, so no false clock edge follows reset
      syncB_q <= 6'h20;
      sclkPrev_q <= 1'b0;
      state_q <= ST_IDLE;
      type_q <= TY_FAST;
      cnt_q <= 5'h00;
      sr_q <= 24'h000000;
      contMode_q <= CONT_NONE;
      wip_q <= 1'b0;
      outSr_q <= 8'h00;
      outCnt_q <= 3'h0;
      dataOut_q <= 4'h0;
      dataOe_q <= 4'h0;
      fetchAddr_q <= {ARRAY_AW{1'b0}};
      fetchOn_q <= 1'b0;
      inflight_q <= 1'b0;
    end else if (clkEn) begin
      syncA_q <= {csN, sclk, dataLineIn};
      syncB_q <= syncA_q;
      sclkPrev_q <= sclkNow;
      wip_q <= cycleBusy;
      if (contModeClear) begin
        contMode_q <= CONT_NONE;
      end
      if (fetchIssue) begin
        fetchAddr_q <= fetchAddr_q + {{(ARRAY_AW-1){1'b0}}, 1'b1};
      end
      inflight_q <= fetchIssue;
      if (!selected) begin
        state_q <= ST_IDLE;
        cnt_q <= 5'h00;
        outCnt_q <= 3'h0;
        dataOe_q <= 4'h0;
        fetchOn_q <= 1'b0;
        inflight_q <= 1'b0;
      end else begin
        state_q <= stCur;
        type_q <= tyCur;
        if (sclkRise) begin
          case (stCur)
            ST_CMD: begin
              sr_q <= shifted;
              cnt_q <= cntNext;
              if (cntNext == `SFR_CMD_CLKS) begin
                cnt_q <= 5'h00;
                state_q <= ST_ADDR;
                if (cycleBusy) begin
                  state_q <= ST_REJECT;
                end else begin
                  case (opcode)
                    `SFR_OP_FAST: type_q <= TY_FAST;
                    `SFR_OP_DOUT: type_q <= TY_DOUT;
                    `SFR_OP_DIO: type_q <= TY_DIO;
                    `SFR_OP_QOUT: begin
                      type_q <= TY_QOUT;
                      if (!quadEnableBit) begin
                        state_q <= ST_REJECT;
                      end
                    end
                    `SFR_OP_QIO: begin
                      type_q <= TY_QIO;
                      if (!quadEnableBit) begin
                        state_q <= ST_REJECT;
                      end
                    end
                    default: state_q <= ST_REJECT;
                  endcase
                end
              end
            end
            ST_ADDR: begin
              sr_q <= shifted;
              cnt_q <= cntNext;
              if (cntNext == addrClks) begin
                cnt_q <= 5'h00;
                fetchAddr_q <= shifted[ARRAY_AW-1:0];
                fetchOn_q <= 1'b1;
                inflight_q <= 1'b0;
                if (modeClks != 5'h00) begin
                  state_q <= ST_MODE;
                end else begin
                  state_q <= ST_DUMMY;
                end
              end
            end
            ST_MODE: begin
              sr_q <= shifted;
              cnt_q <= cntNext;
              if (cntNext == modeClks) begin
                cnt_q <= 5'h00;
                if (shifted[`SFR_CONT_POS+1:`SFR_CONT_POS] == `SFR_CONT_KEEP) begin
                  contMode_q <= (tyCur == TY_QIO) ? CONT_QUAD : CONT_DUAL;
                end else begin
                  contMode_q <= CONT_NONE;
                end
                if (dummyClks != 5'h00) begin
                  state_q <= ST_DUMMY;
                end else begin
                  state_q <= ST_DATA;
                end
              end
            end
            ST_DUMMY: begin
              // Inputs during dummy clocks are never looked at
              cnt_q <= cntNext;
              if (cntNext == dummyClks) begin
                cnt_q <= 5'h00;
                state_q <= ST_DATA;
              end
            end
            default: begin
              cnt_q <= cnt_q;
            end
          endcase
        end
        if ((state_q == ST_DATA) && sclkFall) begin
          // Lines turn around only on the first data falling edge
          case (dataLanes)
            3'h2: begin
              dataOut_q <= {2'b00, byteNow[7:6]};
              dataOe_q <= 4'h3;
              outSr_q <= {byteNow[5:0], 2'b00};
              outCnt_q <= (outCnt_q == 3'h0) ? 3'h3 : outCnt_q - 3'h1;
            end
            3'h4: begin
              dataOut_q <= byteNow[7:4];
              dataOe_q <= 4'hF;
              outSr_q <= {byteNow[3:0], 4'h0};
              outCnt_q <= (outCnt_q == 3'h0) ? 3'h1 : outCnt_q - 3'h1;
            end
            default: begin
              dataOut_q <= {2'b00, byteNow[7], 1'b0};
              dataOe_q <= 4'h2;
              outSr_q <= {byteNow[6:0], 1'b0};
              outCnt_q <= (outCnt_q == 3'h0) ? 3'h7 : outCnt_q - 3'h1;
            end
          endcase
        end
      end
    end
  end

  // Prefetch keeps the FIFO ahead of the serialiser; a deselect flushes it
  sfr_array #(
    .AW(ARRAY_AW),
    .DW(8)
  ) uArray (
    .clk(clk),
    .clkEn(clkEn),
    .wrEn(loadEn),
    .wrAddr(loadAddr),
    .wrData(loadData),
    .rdEn(fetchIssue),
    .rdAddr(fetchAddr_q),
    .rdData(arrayData)
  );

  sfr_fifo #(
    .WIDTH(`SFR_FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) uFifo (
    .clk(clk),
    .resetn(resetn),
    .clkEn(clkEn),
    .flush(~selected),
    .inValid(inflight_q & selected),
    .inReady(fifoInReady),
    .inData(arrayData),
    .outValid(fifoOutValid),
    .outReady(popByte),
    .outData(fifoOutData)
  );

  assign dataLineOut = dataOut_q;
  assign dataLineOe = dataOe_q;
  assign writeInProgressBit = wip_q;
  assign continuousModeActive = (contMode_q != CONT_NONE);
  assign readActive = (state_q == ST_DATA);
  assign readRejected = (state_q == ST_REJECT);
endmodule

// *** rtl/sfr_read_regs.vh ***
// Constants for the serial flash multi-line read front end.
// Included by the top design file of the read block; definitions only.
`ifndef SFR_READ_REGS_VH
`define SFR_READ_REGS_VH

// Read opcodes
`define SFR_OP_FAST 8'h0B
`define SFR_OP_DOUT 8'h3B
`define SFR_OP_DIO 8'hBB
`define SFR_OP_QOUT 8'h6B
`define SFR_OP_QIO 8'hEB

// Phase lengths in serial clocks
`define SFR_CMD_CLKS 5'h08
`define SFR_ADDR_CLKS_X1 5'h18
`define SFR_ADDR_CLKS_X2 5'h0C
`define SFR_ADDR_CLKS_X4 5'h06
`define SFR_MODE_CLKS_DIO 5'h04
`define SFR_MODE_CLKS_QIO 5'h02
`define SFR_DUMMY_CLKS_SER 5'h08
`define SFR_DUMMY_CLKS_QIO 5'h04

// Continuous mode field of the mode byte
`define SFR_CONT_POS 4
`define SFR_CONT_KEEP 2'h2

// Sizes
`define SFR_ADDR_BITS 24
`define SFR_ARRAY_AW 20
`define SFR_FIFO_DEPTH 32
`define SFR_FIFO_WIDTH 8

`endif

// *** test/sfr_host_model.sv ***
// Host side of the serial link: select, serial clock and data lanes.
// Assumes clk at 100 MHz; one serial clock spans eight clk cycles.
`timescale 1ns/1ps
module sfr_host_model (
  // Clock
  input wire clk,
  // Device side of the lanes
  input wire [3:0] devOut,
  input wire [3:0] devOe,
  // Link pins
  output reg csN,
  output reg sclk,
  output wire [3:0] lineIn
);
  reg [3:0] hv;
  reg [3:0] seen;
  // Released lanes toggle so a stale level can never pass for data
  assign lineIn = (devOe & devOut) | (~devOe & hv);
  initial begin
    csN = 1'b1;
    sclk = 1'b0;
    hv = 4'h5;
  end
  task wt(input integer n);
    repeat (n) @(posedge clk);
  endtask
  // Mode 0: lanes set after the fall, lanes read just before the next fall
  task cyc(input [3:0] v, input [3:0] en);
    begin
      @(posedge clk) hv <= (v & en) | (~hv & ~en);
      wt(2);
      @(posedge clk) sclk <= 1'b1;
      wt(3);
      @(negedge clk) seen = lineIn;
      @(posedge clk) sclk <= 1'b0;
    end
  endtask
  task sel;
    begin
      @(posedge clk) csN <= 1'b0;
      wt(4);
    end
  endtask
  task desel;
    begin
      wt(4);
      @(posedge clk) csN <= 1'b1;
      wt(12);
    end
  endtask
  // MSB first, w lanes per clock, line 0 carries the lowest bit of a group
  task send(input [31:0] v, input integer n, input integer w);
    integer i, k;
    reg [3:0] t;
    begin
      for (i = 0; i < n; i = i + w) begin
        for (k = 0; k < 4; k = k + 1)
          t[k] = (k < w) ? v[n - 1 - i - (w - 1 - k)] : 1'b0;
        cyc(t, w == 4 ? 4'hF : w == 2 ? 4'h3 : 4'h1);
      end
    end
  endtask
  task idle(input integer n);
    repeat (n) cyc(4'h0, 4'h0);
  endtask
  task recv(output [7:0] b, input integer w);
    integer i;
    begin
      b = 8'h00;
      for (i = 0; i < 8; i = i + w) begin
        cyc(4'h0, 4'h0);
        if (w == 1) b = {b[6:0], seen[1]};
        else if (w == 2) b = {b[5:0], seen[1:0]};
        else b = {b[3:0], seen};
      end
    end
  endtask
endmodule

// *** test/sfr_multi_io_read_bench.sv ***
// Self-checking bench for the multi-line read front end.
// Assumes the host model drives the link and the checker is bound.
`timescale 1ns/1ps
module sfr_multi_io_read_bench;
  localparam AW = 20;
  reg clk = 1'b0;
  reg resetn = 1'b0;
  reg clkEn = 1'b1;
  reg quadEn = 1'b0;
  reg busy = 1'b0;
  reg contClr = 1'b0;
  reg loadEn = 1'b0;
  reg [AW-1:0] loadAddr = 20'h00000;
  reg [7:0] loadData = 8'h00;
  wire csN;
  wire sclk;
  wire [3:0] lineIn;
  wire [3:0] lineOut;
  wire [3:0] lineOe;
  wire write_in_progress_bit;
  wire contAct;
  wire rej;
  wire act;
  integer n_errors = 0;
  integer checks = 0;
  integer cycles = 0;
  always #5 clk = ~clk;
  sfr_multi_io_read #(.ARRAY_AW(AW)) uut (
    .clk(clk), .resetn(resetn), .clkEn(clkEn), .csN(csN), .sclk(sclk),
    .dataLineIn(lineIn), .dataLineOut(lineOut), .dataLineOe(lineOe),
    .quadEnableBit(quadEn), .cycleBusy(busy), .contModeClear(contClr),
    .writeInProgressBit(write_in_progress_bit), .continuousModeActive(contAct), .readActive(act),
    .readRejected(rej), .loadEn(loadEn), .loadAddr(loadAddr), .loadData(loadData));
  sfr_host_model host (.clk(clk), .devOut(lineOut), .devOe(lineOe), .csN(csN),
    .sclk(sclk), .lineIn(lineIn));
  task end_of_test;
    begin
      if (n_errors == 0 && checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task check(input [7:0] seen, input [7:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("ERROR %0t: got %h, expected %h", $time, seen, exp);
      end
    end
  endtask
  // Byte pattern ignores address bits 3:0, so addresses within one 16-byte block read back equal
  function [7:0] pat(input [AW-1:0] x);
    pat = x[7:0] ^ x[15:8] ^ {x[19:16], x[3:0]} ^ 8'hA5;
  endfunction
  task load(input [AW-1:0] a);
    begin
      @(posedge clk);
      loadEn <= 1'b1;
      loadAddr <= a;
      loadData <= pat(a);
      @(posedge clk) loadEn <= 1'b0;
    end
  endtask
  task rd(input [7:0] op, input opEn, input integer aw, input [23:0] a, input integer mw,
    input [7:0] m, input integer dc, input integer dw, input integer n);
    integer i;
    reg [7:0] b;
    begin
      for (i = 0; i < n; i = i + 1)
        load(a[AW-1:0] + i[AW-1:0]);
      host.sel;
      if (opEn) host.send({24'h0, op}, 8, 1);
      host.send({8'h0, a}, 24, aw);
      if (mw != 0) host.send({24'h0, m}, 8, mw);
      host.idle(dc);
      for (i = 0; i < n; i = i + 1) begin
        host.recv(b, dw);
        check(b, pat(a[AW-1:0] + i[AW-1:0]));
      end
      check({7'h0, act}, 8'h01);
      host.desel;
      check({4'h0, lineOe}, 8'h00);
    end
  endtask
  task rj(input [7:0] op);
    begin
      host.sel;
      host.send({24'h0, op}, 8, 1);
      host.idle(4);
      check({7'h0, rej}, 8'h01);
      check({4'h0, lineOe}, 8'h00);
      check({7'h0, act}, 8'h00);
      host.desel;
    end
  endtask
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      $display("ERROR %0t: run too long", $time);
      end_of_test;
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    check({7'h0, contAct}, 8'h00);
    rd(8'h0B, 1'b1, 1, 24'h0FFFFE, 0, 8'h00, 8, 1, 4);
    rd(8'h3B, 1'b1, 1, 24'h012345, 0, 8'h00, 8, 2, 3);
    quadEn <= 1'b1;
    rd(8'h6B, 1'b1, 1, 24'h0ABCDE, 0, 8'h00, 8, 4, 3);
    rd(8'hBB, 1'b1, 2, 24'h0FFFFF, 2, 8'h20, 0, 2, 2);
    check({7'h0, contAct}, 8'h01);
    rd(8'h00, 1'b0, 2, 24'h055AA0, 2, 8'h00, 0, 2, 2);
    check({7'h0, contAct}, 8'h00);
    rd(8'hEB, 1'b1, 4, 24'h00F0F0, 4, 8'h20, 4, 4, 3);
    check({7'h0, contAct}, 8'h01);
    rd(8'h00, 1'b0, 4, 24'h077777, 4, 8'hA5, 4, 4, 2);
    @(posedge clk) contClr <= 1'b1;
    @(posedge clk) contClr <= 1'b0;
    repeat (3) @(posedge clk);
    check({7'h0, contAct}, 8'h00);
    rd(8'hEB, 1'b1, 4, 24'h0C0001, 4, 8'hFF, 4, 4, 2);
    check({7'h0, contAct}, 8'h00);
    rd(8'hEB, 1'b1, 4, 24'h000010, 4, 8'h20, 4, 4, 1);
    check({7'h0, contAct}, 8'h01);
    @(posedge clk) resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    check({7'h0, contAct}, 8'h00);
    quadEn <= 1'b0;
    rj(8'h6B);
    rj(8'hEB);
    quadEn <= 1'b1;
    clkEn <= 1'b0;
    busy <= 1'b1;
    repeat (3) @(posedge clk);
    check({7'h0, write_in_progress_bit}, 8'h00);
    clkEn <= 1'b1;
    repeat (3) @(posedge clk);
    check({7'h0, write_in_progress_bit}, 8'h01);
    rj(8'h0B);
    rj(8'hEB);
    busy <= 1'b0;
    repeat (3) @(posedge clk);
    check({7'h0, write_in_progress_bit}, 8'h00);
    rd(8'hEB, 1'b1, 4, 24'h0FFFF0, 4, 8'h20, 4, 4, 1);
    busy <= 1'b1;
    repeat (3) @(posedge clk);
    rj(8'h00);
    busy <= 1'b0;
    repeat (3) @(posedge clk);
    rd(8'h00, 1'b0, 4, 24'h0FFFF8, 4, 8'h00, 4, 4, 1);
    check({7'h0, contAct}, 8'h00);
    end_of_test;
  end
endmodule

// *** test/sfr_multi_io_read_checker.sv ***
// Pin-level assertions for the multi-line read front end.
// Assumes one clk domain; bound to every instance of the top module.
`timescale 1ns/1ps
module sfr_multi_io_read_checker (
  // Clock and reset
  input wire clk,
  input wire resetn,
  input wire clkEn,
  // Link pins
  input wire csN,
  input wire [3:0] dataLineOe,
  // Status
  input wire quadEnableBit,
  input wire cycleBusy,
  input wire contModeClear,
  input wire writeInProgressBit,
  input wire continuousModeActive,
  input wire readActive,
  input wire readRejected
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  AST_WIP_DELAY: assert property (clkEn |=> writeInProgressBit == $past(cycleBusy))
    else $error("busy flag lags wrongly");
  // Six samples cover the two-stage select synchroniser plus the output register
  AST_DESEL_OE: assert property (csN [*6] |-> dataLineOe == 4'h0)
    else $error("lines driven while deselected");
  AST_DESEL_IDLE: assert property (csN [*6] |-> !readActive && !readRejected)
    else $error("read state kept after deselect");
  AST_LANE_SET: assert property (dataLineOe == 4'h0 || dataLineOe == 4'h2 ||
    dataLineOe == 4'h3 || dataLineOe == 4'hF)
    else $error("illegal lane enable set");
  AST_QUAD_OFF: assert property ((!quadEnableBit && !csN) [*8] |-> dataLineOe[3:2] == 2'h0)
    else $error("upper lanes driven without quad enable");
  AST_BUSY_QUIET: assert property ((cycleBusy && !csN) [*8] |-> dataLineOe == 4'h0)
    else $error("read answered while busy");
  AST_REJECT_HOLD: assert property (readRejected && !csN |=> readRejected)
    else $error("rejection dropped while selected");
  AST_REJECT_SILENT: assert property (readRejected |-> dataLineOe == 4'h0)
    else $error("rejected selection drives lines");
  AST_DRIVE_IN_READ: assert property ($rose(dataLineOe != 4'h0) |-> readActive && !csN)
    else $error("drive started outside data phase");
  AST_CONT_CLEAR: assert property (contModeClear && csN |-> ##[1:2] !continuousModeActive)
    else $error("continuous mode survives clear");
endmodule

bind sfr_multi_io_read sfr_multi_io_read_checker chk (
  .clk(clk), .resetn(resetn), .clkEn(clkEn), .csN(csN), .dataLineOe(dataLineOe),
  .quadEnableBit(quadEnableBit), .cycleBusy(cycleBusy), .contModeClear(contModeClear),
  .writeInProgressBit(writeInProgressBit), .continuousModeActive(continuousModeActive),
  .readActive(readActive), .readRejected(readRejected));
